// ==== hw/tpos_pkg.sv ====
package tpos_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DEAD   = 8'h08;
  localparam logic [7:0] ADDR_PBUF   = 8'h0c;
  localparam logic [7:0] ADDR_DUTY_U = 8'h10;
  localparam logic [7:0] ADDR_DUTY_V = 8'h14;
  localparam logic [7:0] ADDR_DUTY_W = 8'h18;
  localparam logic [7:0] ADDR_PDATA  = 8'h1c;
  localparam logic [7:0] ADDR_COUNT  = 8'h20;
  localparam logic [7:0] ADDR_PINS   = 8'h24;

  // control register bits
  localparam int unsigned CTL_RUN      = 0;
  localparam int unsigned CTL_OUT_EN   = 1;
  localparam int unsigned CTL_POS_LVL  = 2;
  localparam int unsigned CTL_NEG_LVL  = 3;
  localparam int unsigned CTL_CREST_IE = 4;
  localparam int unsigned CTL_TROUGH_IE = 5;
  localparam int unsigned CTL_XFER_CR  = 6;
  localparam int unsigned CTL_XFER_TR  = 7;
  localparam int unsigned CTL_DMA_EN   = 8;
  localparam logic [8:0]  CTL_RESET    = 9'h00c;

  // status register bits
  localparam int unsigned ST_CREST  = 0;
  localparam int unsigned ST_TROUGH = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] CNT_RESET  = 16'h0000;
  localparam logic [15:0] PER_RESET  = 16'hffff;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } tpos_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tpos_axi_rsp_t;

  // per-phase waveforms from the compare and dead-time core, index 0=u
  typedef struct packed {
    logic [2:0] compare_wave_a;
    logic [2:0] compare_wave_b;
    logic [2:0] deadtime_wave_a;
    logic [2:0] deadtime_wave_b;
  } tpos_wave_t;

endpackage : tpos_pkg

// ==== hw/tpos_output_stage.sv ====
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
module tpos_output_stage
  import tpos_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire tpos_axi_req_t axi_req,
  output tpos_axi_rsp_t      axi_rsp,
  input  wire tpos_wave_t    wave,
  input  wire logic          counter_clear_n,
  input  wire logic [3:0]    shutdown_req_n,
  input  wire logic          clock_stop_det,
  input  wire logic [1:0]    transfer_ack,
  output logic [5:0]         pwm_pin_o,
  output logic [5:0]         pwm_pin_oe,
  output logic               period_toggle_output,
  output logic               crest_irq,
  output logic               trough_irq,
  output logic [1:0]         transfer_req
);

  typedef struct packed {
    tpos_axi_rsp_t rsp;
    logic          aw_have;
    logic [7:0]    aw_addr;
    logic          w_have;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic [8:0]    timer_control_reg;
    logic [1:0]    compare_flag;
    logic [1:0]    flag_armed;
    logic [15:0]   deadtime_reg;
    logic [15:0]   period_buffer_reg;
    logic [15:0]   period_data_reg;
    logic [2:0][15:0] duty_buf;
    logic [2:0][15:0] duty_act;
    logic [15:0]   carrier_counter;
    logic          count_up;
    logic [1:0]    match;
    logic [1:0]    clr_sync;
    logic          clr_prev;
    logic [3:0]    sd_meta;
    logic [3:0]    sd_sync;
    logic [1:0]    stop_sync;
    logic [5:0]    pin;
    logic [5:0]    oe;
    logic          toggle;
    logic          crest_irq;
    logic          trough_irq;
    logic [1:0]    xfer_req;
  } tpos_state_t;

  tpos_state_t st_r;
  tpos_state_t st_nxt;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    logic [15:0] r;
    r = old;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r;
  endfunction : merge16

  function automatic logic map_ok(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= ADDR_PINS);
  endfunction : map_ok

  // level bit one passes the waveform, zero drives its inverse
  function automatic logic lvl(input logic sel,
                               input logic w);
    return sel ? w : !w;
  endfunction : lvl

  // one phase: {negative, positive} generation levels
  function automatic logic [1:0] gen_phase(input logic        ca,
                                           input logic        cb,
                                           input logic        da,
                                           input logic        db,
                                           input logic [15:0] duty,
                                           input logic [15:0] per);
    logic [1:0] r;
    r = {cb && da, ca && db};
    if (duty == 16'h0000)
      r = 2'b01;
    else if (duty > per)
      r = 2'b10;
    return r;
  endfunction : gen_phase

  // read decode; unmapped words read as zero
  function automatic logic [31:0] rd_word(input tpos_state_t s,
                                          input logic [7:0]  a);
    logic [31:0] r;
    case (a)
      ADDR_CTRL:   r = {23'h0, s.timer_control_reg};
      ADDR_STATUS: r = {30'h0, s.compare_flag};
      ADDR_DEAD:   r = {16'h0, s.deadtime_reg};
      ADDR_PBUF:   r = {16'h0, s.period_buffer_reg};
      ADDR_DUTY_U: r = {16'h0, s.duty_buf[0]};
      ADDR_DUTY_V: r = {16'h0, s.duty_buf[1]};
      ADDR_DUTY_W: r = {16'h0, s.duty_buf[2]};
      ADDR_PDATA:  r = {16'h0, s.period_data_reg};
      ADDR_COUNT:  r = {15'h0, s.count_up, s.carrier_counter};
      ADDR_PINS:   r = {25'h0, s.stop_sync[1], ~s.sd_sync, s.oe[0],
                        s.toggle};
      default:     r = 32'h0;
    endcase
    return r;
  endfunction : rd_word

  logic [15:0] two_td;
  logic        clr_fall;
  logic        shut;
  logic        wr_go;
  logic        rd_go;
  logic [31:0] rd_val;
  logic [5:0]  og;
  logic        xfer;
  logic [16:0] per_sum;

  always_comb begin
    st_nxt = st_r;
    two_td = {st_r.deadtime_reg[14:0], 1'b0};
    clr_fall = st_r.clr_prev && !st_r.clr_sync[1];
    shut = !(&st_r.sd_sync) || st_r.stop_sync[1];

    // input synchronisers
    st_nxt.clr_sync = {st_r.clr_sync[0], counter_clear_n};
    st_nxt.clr_prev = st_r.clr_sync[1];
    st_nxt.sd_meta = shutdown_req_n;
    st_nxt.sd_sync = st_r.sd_meta;
    st_nxt.stop_sync = {st_r.stop_sync[0], clock_stop_det};

    // carrier counter
    if (st_r.timer_control_reg[CTL_RUN]) begin
      if (clr_fall) begin
        st_nxt.carrier_counter = two_td;
        st_nxt.count_up = 1'b1;
      end else if (st_r.count_up) begin
        if (st_r.carrier_counter >= st_r.period_data_reg) begin
          st_nxt.count_up = 1'b0;
          st_nxt.carrier_counter = st_r.carrier_counter - 16'h0001;
        end else begin
          st_nxt.carrier_counter = st_r.carrier_counter + 16'h0001;
        end
      end else begin
        if (st_r.carrier_counter <= two_td) begin
          st_nxt.count_up = 1'b1;
          st_nxt.carrier_counter = st_r.carrier_counter + 16'h0001;
        end else begin
          st_nxt.carrier_counter = st_r.carrier_counter - 16'h0001;
        end
      end
      st_nxt.toggle = st_nxt.count_up;
    end
    // while halted the counter, its direction and the toggle are held; the synchronisers keep sampling

    // compare matches; flags follow one clock later
    st_nxt.match[ST_CREST] = st_r.timer_control_reg[CTL_RUN]
      && (st_r.carrier_counter == st_r.period_data_reg);
    st_nxt.match[ST_TROUGH] = st_r.timer_control_reg[CTL_RUN]
      && (st_r.carrier_counter == two_td);

    // buffer transfer at selected extreme, or at once while halted
    xfer = !st_r.timer_control_reg[CTL_RUN]
      || (st_r.match[ST_CREST] && st_r.timer_control_reg[CTL_XFER_CR])
      || (st_r.match[ST_TROUGH] && st_r.timer_control_reg[CTL_XFER_TR]);
    per_sum = {1'b0, st_r.period_buffer_reg} + {1'b0, two_td};
    if (xfer) begin
      st_nxt.period_data_reg = per_sum[15:0];
      st_nxt.duty_act = st_r.duty_buf;
    end

    // output generation
    for (int p = 0; p < 3; p++) begin
      {og[p+3], og[p]} = gen_phase(wave.compare_wave_a[p],
        wave.compare_wave_b[p], wave.deadtime_wave_a[p],
        wave.deadtime_wave_b[p], st_r.duty_act[p],
        st_r.period_data_reg);
    end
    // pins only move while running, so a halt freezes them
    if (st_r.timer_control_reg[CTL_RUN]) begin
      for (int p = 0; p < 3; p++) begin
        // level one passes, zero inverts
        st_nxt.pin[p] = lvl(st_r.timer_control_reg[CTL_POS_LVL],
          og[p]);
        st_nxt.pin[p+3] = lvl(st_r.timer_control_reg[CTL_NEG_LVL],
          og[p+3]);
      end
    end
    // protection overrides the enable three edges after the request input, through the synchroniser
    // clock loss is seen only through the external detector input
    st_nxt.oe = (st_r.timer_control_reg[CTL_OUT_EN] && !shut)
      ? 6'h3f : 6'h00;

    // axi write side
    if (axi_req.awvalid && st_r.rsp.awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_r.rsp.wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.w_data = axi_req.wdata;
      st_nxt.w_strb = axi_req.wstrb;
    end
    if (st_r.rsp.bvalid && axi_req.bready) st_nxt.rsp.bvalid = 1'b0;
    wr_go = st_r.aw_have && st_r.w_have && !st_r.rsp.bvalid;
    if (wr_go) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.rsp.bvalid = 1'b1;
      st_nxt.rsp.bresp = map_ok(st_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      case (st_r.aw_addr)
        ADDR_CTRL: begin
          if (st_r.w_strb[0])
            st_nxt.timer_control_reg[7:0] = st_r.w_data[7:0];
          if (st_r.w_strb[1])
            st_nxt.timer_control_reg[8] = st_r.w_data[8];
        end
        ADDR_STATUS: begin
          if (st_r.w_strb[0]) begin
            for (int f = 0; f < 2; f++) begin
              if (!st_r.w_data[f] && st_r.flag_armed[f]) begin
                st_nxt.compare_flag[f] = 1'b0;
                st_nxt.flag_armed[f] = 1'b0;
              end
            end
          end
        end
        ADDR_DEAD: st_nxt.deadtime_reg =
          merge16(st_r.deadtime_reg, st_r.w_data, st_r.w_strb);
        ADDR_PBUF: st_nxt.period_buffer_reg =
          merge16(st_r.period_buffer_reg, st_r.w_data, st_r.w_strb);
        ADDR_DUTY_U: st_nxt.duty_buf[0] =
          merge16(st_r.duty_buf[0], st_r.w_data, st_r.w_strb);
        ADDR_DUTY_V: st_nxt.duty_buf[1] =
          merge16(st_r.duty_buf[1], st_r.w_data, st_r.w_strb);
        ADDR_DUTY_W: st_nxt.duty_buf[2] =
          merge16(st_r.duty_buf[2], st_r.w_data, st_r.w_strb);
        default: begin
        end
      endcase
    end
    st_nxt.rsp.awready = !st_nxt.aw_have;
    st_nxt.rsp.wready = !st_nxt.w_have;

    // axi read side
    rd_val = rd_word(st_r, axi_req.araddr);
    if (st_r.rsp.rvalid && axi_req.rready) st_nxt.rsp.rvalid = 1'b0;
    rd_go = axi_req.arvalid && st_r.rsp.arready;
    if (rd_go) begin
      st_nxt.rsp.rvalid = 1'b1;
      st_nxt.rsp.rdata = rd_val;
      st_nxt.rsp.rresp = map_ok(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
      // a flag seen as one may now be cleared by a zero write
      if (axi_req.araddr == ADDR_STATUS)
        st_nxt.flag_armed = st_nxt.flag_armed | st_r.compare_flag;
    end
    st_nxt.rsp.arready = !st_nxt.rsp.rvalid;

    // acknowledged transfers clear their flag
    for (int f = 0; f < 2; f++) begin
      if (transfer_ack[f] && st_r.xfer_req[f]) begin
        st_nxt.compare_flag[f] = 1'b0;
        st_nxt.flag_armed[f] = 1'b0;
      end
    end
    // a new match wins over any clear in the same cycle
    st_nxt.compare_flag = st_nxt.compare_flag | st_r.match;
    st_nxt.flag_armed = st_nxt.flag_armed & st_nxt.compare_flag;

    // requests follow the flag value that is being registered
    st_nxt.crest_irq = st_nxt.compare_flag[ST_CREST]
      && st_r.timer_control_reg[CTL_CREST_IE];
    st_nxt.trough_irq = st_nxt.compare_flag[ST_TROUGH]
      && st_r.timer_control_reg[CTL_TROUGH_IE];
    st_nxt.xfer_req = st_r.timer_control_reg[CTL_DMA_EN]
      ? st_nxt.compare_flag : 2'h0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.rsp.awready <= 1'b1;
      st_r.rsp.wready <= 1'b1;
      st_r.rsp.arready <= 1'b1;
      st_r.timer_control_reg <= CTL_RESET;
      st_r.period_data_reg <= PER_RESET;
      st_r.carrier_counter <= CNT_RESET;
      st_r.count_up <= 1'b1;
      st_r.toggle <= 1'b1;
      st_r.clr_sync <= 2'h3;
      st_r.clr_prev <= 1'b1;
      st_r.sd_meta <= 4'hf;
      st_r.sd_sync <= 4'hf;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign axi_rsp = st_r.rsp;
  assign pwm_pin_o = st_r.pin;
  assign pwm_pin_oe = st_r.oe;
  assign period_toggle_output = st_r.toggle;
  assign crest_irq = st_r.crest_irq;
  assign trough_irq = st_r.trough_irq;
  assign transfer_req = st_r.xfer_req;

endmodule : tpos_output_stage

// ==== tb/tpos_props.sv ====
`timescale 1ns/100ps
module tpos_checker
  import tpos_pkg::*;
(
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire tpos_axi_rsp_t axi_rsp,
  input wire logic [3:0]    shutdown_req_n,
  input wire logic          clock_stop_det,
  input wire logic [1:0]    transfer_ack,
  input wire logic [5:0]    pwm_pin_oe,
  input wire logic          period_toggle_output,
  input wire logic          crest_irq,
  input wire logic          trough_irq,
  input wire logic [1:0]    transfer_req
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // three edges through the synchroniser and the enable register
  property p_shut;
    (shutdown_req_n != 4'hf) [*4] |-> pwm_pin_oe == 6'h00;
  endproperty
  a_shut: assert property (p_shut) else $error("oe on in shutdown");
  property p_stop; clock_stop_det [*4] |-> pwm_pin_oe == 6'h00; endproperty
  a_stop: assert property (p_stop) else $error("oe on, clock lost");
  property p_crest; $rose(crest_irq) |-> !period_toggle_output; endproperty
  a_crest: assert property (p_crest) else $error("crest off peak");
  property p_trough; $rose(trough_irq) |-> period_toggle_output; endproperty
  a_trough: assert property (p_trough) else $error("trough off");
  // a request only drops after a bus write or an acknowledge
  property p_clr;
    $fell(crest_irq) |-> axi_rsp.bvalid
      || $past(axi_rsp.bvalid | transfer_ack[0])
      || $past(axi_rsp.bvalid | transfer_ack[0], 2);
  endproperty
  a_clr: assert property (p_clr) else $error("irq dropped alone");
  property p_ack_c; transfer_req[0] && transfer_ack[0] |=> !transfer_req[0];
  endproperty
  a_ack_c: assert property (p_ack_c) else $error("crest req kept");
  property p_ack_t; transfer_req[1] && transfer_ack[1] |=> !transfer_req[1];
  endproperty
  a_ack_t: assert property (p_ack_t) else $error("trough req kept");
  property p_treq; $rose(transfer_req[0]) |-> !period_toggle_output;
  endproperty
  a_treq: assert property (p_treq) else $error("transfer off peak");
  c_crest: cover property ($rose(crest_irq));
  c_trough: cover property ($rose(trough_irq));
  c_off: cover property ($fell(pwm_pin_oe[0]));
endmodule : tpos_checker

bind tpos_output_stage tpos_checker i_chk (.aclk, .aresetn, .axi_rsp,
  .shutdown_req_n, .clock_stop_det, .transfer_ack, .pwm_pin_oe,
  .period_toggle_output, .crest_irq, .trough_irq, .transfer_req);

// ==== tb/tpos_far_side.sv ====
`timescale 1ns/100ps
module tpos_far_side (
  input  wire logic       aclk,
  input  wire logic       clear_go,
  input  wire logic [5:0] pwm_pin_o,
  input  wire logic [5:0] pwm_pin_oe,
  output logic            counter_clear_n,
  output logic [5:0]      pin_wire
);
  logic [5:0] last_r = 6'h00;
  logic [2:0] low_r = 3'h0;
  initial counter_clear_n = 1'b1;
  // held low several clocks so two samples see it
  always @(posedge aclk) begin
    if (clear_go)
      low_r <= 3'h4;
    else if (low_r != 3'h0)
      low_r <= low_r - 3'h1;
    // the clear pin is only ever an input to the block
    counter_clear_n <= (low_r == 3'h0) && !clear_go;
    last_r <= (pwm_pin_oe & pwm_pin_o) | (~pwm_pin_oe & last_r);
  end
  // a floating gate input shows the opposite of its last level
  assign pin_wire = (pwm_pin_oe & pwm_pin_o) | (~pwm_pin_oe & ~last_r);
endmodule : tpos_far_side

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  import tpos_pkg::*;
  localparam logic [31:0] DT = 32'h2;
  localparam logic [31:0] PB = 32'h28;
  logic          aclk = 1'b0;
  logic          aresetn = 1'b0;
  tpos_axi_req_t req;
  tpos_axi_rsp_t rsp;
  tpos_wave_t    wave;
  logic [3:0]    shut_n = 4'hf;
  logic          stop_det = 1'b0;
  logic [1:0]    ack = 2'h0;
  logic          ack_on = 1'b0;
  logic          clear_go = 1'b0;
  logic          clear_n, tog, cirq, tirq;
  logic [5:0]    pwm_o, pwm_oe, pin_wire;
  logic [1:0]    treq, resp;
  logic [31:0]   rdat, c;
  int            n_errors = 0;
  int            comparisons = 0;

  always #50 aclk = ~aclk;
  always @(posedge aclk) ack <= treq & ~ack & {2{ack_on}};

  tpos_output_stage i_dut (.aclk, .aresetn, .axi_req(req), .axi_rsp(rsp),
    .wave, .counter_clear_n(clear_n), .shutdown_req_n(shut_n),
    .clock_stop_det(stop_det), .transfer_ack(ack), .pwm_pin_o(pwm_o),
    .pwm_pin_oe(pwm_oe), .period_toggle_output(tog), .crest_irq(cirq),
    .trough_irq(tirq), .transfer_req(treq));
  tpos_far_side i_far (.aclk, .clear_go, .pwm_pin_o(pwm_o),
    .pwm_pin_oe(pwm_oe), .counter_clear_n(clear_n), .pin_wire);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    resp = rsp.bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    rdat = rsp.rdata;
    resp = rsp.rresp;
  endtask : rd

  task automatic tally_and_finish();
    $display("compared %0d, mismatched %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (3000) @(posedge aclk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    wave = {3'h7, 3'h0, 3'h7, 3'h7};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTRL);
    chk(rdat, 32'(CTL_RESET), "ctrl reset");
    rd(ADDR_PDATA);
    chk(rdat, 32'h0, "period follows buffer");
    rd(8'h28);
    chk(32'(resp), 32'(RESP_SLVERR), "unmapped read");
    chk(rdat, 32'h0, "unmapped data");
    wr(8'h30, 32'h0);
    chk(32'(resp), 32'(RESP_SLVERR), "unmapped write");
    $display("test registers done");
    wr(ADDR_DEAD, DT);
    wr(ADDR_PBUF, PB);
    wr(ADDR_DUTY_U, 32'h0);
    wr(ADDR_DUTY_V, PB + 4 * DT + 32'h4);
    wr(ADDR_DUTY_W, 32'ha);
    rd(ADDR_PDATA);
    chk(rdat, PB + 2 * DT, "period data");
    wr(ADDR_CTRL, 32'h1ff);
    repeat (100) if (!cirq) @(posedge aclk);
    chk(32'(cirq), 32'h1, "crest irq");
    chk(32'(tog), 32'h0, "toggle at crest");
    chk(32'(treq), 32'h3, "transfer requests");
    chk(32'(pin_wire), 32'h15, "pins");
    chk(32'(pwm_oe), 32'h3f, "outputs on");
    wave.deadtime_wave_b <= 3'h3;
    repeat (3) @(posedge aclk);
    chk(32'(pin_wire), 32'h11, "gated phase");
    wr(ADDR_CTRL, 32'h1f3);
    repeat (3) @(posedge aclk);
    chk(32'(pin_wire), 32'h2e, "levels low");
    wr(ADDR_CTRL, 32'h1ff);
    repeat (3) @(posedge aclk);
    $display("test pins done");
    wr(ADDR_CTRL, 32'h1fe);
    rd(ADDR_COUNT);
    c = rdat;
    wave <= '0;
    repeat (5) @(posedge aclk);
    chk(32'(pin_wire), 32'h11, "pins held");
    rd(ADDR_COUNT);
    chk(rdat, c, "count held");
    wr(ADDR_STATUS, 32'h0);
    @(posedge aclk);
    chk(32'(cirq), 32'h1, "unarmed clear");
    rd(ADDR_STATUS);
    chk(rdat, 32'h3, "both flags");
    wr(ADDR_STATUS, 32'h0);
    @(posedge aclk);
    chk(32'({cirq, tirq}), 32'h0, "irqs cleared");
    $display("test halt and flags done");
    wr(ADDR_CTRL, 32'h1ff);
    repeat (100) if (!cirq) @(posedge aclk);
    rd(ADDR_STATUS);
    wr(ADDR_STATUS, 32'h0);
    clear_go <= 1'b1;
    @(posedge aclk);
    clear_go <= 1'b0;
    repeat (8) if (!tirq) @(posedge aclk);
    chk(32'(tirq), 32'h1, "trough after clear");
    $display("test external clear done");
    wr(ADDR_CTRL, 32'h1fe);
    rd(ADDR_STATUS);
    wr(ADDR_STATUS, 32'h0);
    ack_on <= 1'b1;
    wr(ADDR_CTRL, 32'h1ff);
    repeat (100) if (!treq[0]) @(posedge aclk);
    chk(32'(treq[0]), 32'h1, "crest transfer");
    repeat (3) @(posedge aclk);
    chk(32'({treq[0], cirq}), 32'h0, "acknowledged");
    $display("test transfer done");
    for (int i = 0; i < 5; i++) begin
      if (i < 4) shut_n[i] <= 1'b0;
      else stop_det <= 1'b1;
      repeat (5) @(posedge aclk);
      chk(32'(pwm_oe), 32'h0, "released");
      shut_n <= 4'hf;
      stop_det <= 1'b0;
      repeat (5) @(posedge aclk);
      chk(32'(pwm_oe), 32'h3f, "driving again");
    end
    $display("test protection done");
    tally_and_finish();
  end
endmodule : testbench
